// ### core/upc_device.sv
/*
 * Device end: configuration registers on the system clock, cell port
 * logic on the link clock, two-entry receive buffer, transmit holder.
 * Assumes register strobes are one-cycle pulses and that software
 * keeps the configuration still once setup-done is set.
 */
`timescale 1ns/10ps
module upc_device (
  // System clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Register port (system clock)
  input wire logic [15:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  // Link
  upc_link_if.device LNK,
  // Header match values and look-up answer (link clock)
  input wire logic [11:0] UNSTR_VPI_I,
  input wire logic [15:0] UNSTR_VCI_I,
  input wire logic LUT_KNOWN_I,
  output logic LUT_REQ_O,
  output logic [15:0] LUT_ADDR_O,
  // Cell verdict (link clock)
  output logic CELL_DONE_O,
  output logic CELL_KEEP_O,
  output logic CELL_UNSTR_O,
  // Received words (link clock)
  output logic RX_VALID_O,
  output logic RX_SOC_O,
  output logic [15:0] RX_DATA_O,
  input wire logic RX_READY_I,
  // Words to transmit (link clock)
  input wire logic TX_VALID_I,
  input wire logic TX_SOC_I,
  input wire logic [15:0] TX_DATA_I,
  output logic TX_READY_O
);
  import upc_pkg::*;

  logic [15:0] cfg;          // Port configuration register
  logic [15:0] cnt;          // Header bit count register
  logic clk_div;             // Internal half-rate port clock
  logic [25:0] sync1;        // First synchroniser stage
  logic [25:0] sync2;        // Settled configuration on link clock
  logic [15:0] lcfg;         // Link-side configuration
  logic [9:0] lcnt;          // Link-side header counts
  logic setup;               // Port configured
  logic rx_sel;              // Receive side polled or Level 1
  logic tx_sel;              // Transmit side polled or Level 1
  logic flow_go;             // Device accepts a word
  logic next_flow_go;        // Next flow permission
  logic flow_q;              // Previous permission
  logic pause;               // Gap after a cell
  logic word_in;             // Word arrives this cycle
  logic [1:0] fill;          // Receive buffer occupancy
  logic [16:0] slot1;        // Second buffer entry
  logic [5:0] widx;          // Word index in cell
  logic [5:0] next_widx;     // Index of arriving word
  logic [31:0] hdr;          // Header collector
  logic [31:0] next_hdr;     // Header with arriving word
  logic hdr_done;            // Arriving word ends the header
  logic cell_end;            // Arriving word ends the cell
  logic is_oam;              // Cell is OAM
  logic unstr_hit;           // Unstructured header match
  logic need_lut;            // Look-up consulted
  logic hold_v;              // Transmit word held
  logic hold_soc;            // Held start of cell
  logic [15:0] hold_d;       // Held transmit word
  logic send;                // Held word goes out

  // Register writes; reserved count bits stay zero
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cfg <= CFG_RESET;
      cnt <= CNT_RESET;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == CFG_OFFSET) begin
        cfg <= REG_WDATA_I;
      end
      if (REG_ADDR_I == CNT_OFFSET) begin
        cnt <= REG_WDATA_I & CNT_MASK;
      end
    end
  end

  // Register reads, zero for unmapped addresses
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 16'h0000;
    end else if (REG_RD_I) begin
      if (REG_ADDR_I == CFG_OFFSET) begin
        REG_RDATA_O <= cfg;
      end else if (REG_ADDR_I == CNT_OFFSET) begin
        REG_RDATA_O <= cnt;
      end else begin
        REG_RDATA_O <= 16'h0000;
      end
    end
  end

  // Internal port clock at half the system rate
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      clk_div <= 1'b0;
    end else begin
      clk_div <= ~clk_div;
    end
  end

  // Both clock pins driven only for the internal source
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      LNK.rx_port_clk <= 1'b0;
      LNK.tx_port_clk <= 1'b0;
      LNK.rx_port_clk_oe <= 1'b0;
      LNK.tx_port_clk_oe <= 1'b0;
    end else begin
      LNK.rx_port_clk <= ~clk_div;
      LNK.tx_port_clk <= ~clk_div;
      LNK.rx_port_clk_oe <= ~cfg[CLKSRC_BIT];
      LNK.tx_port_clk_oe <= ~cfg[CLKSRC_BIT];
    end
  end

  // Configuration crosses as quasi-static levels
  always_ff @(posedge LNK.link_clk or posedge RST_I) begin
    if (RST_I) begin
      sync1 <= 26'h0;
      sync2 <= 26'h0;
    end else begin
      sync1 <= {cnt[9:0], cfg};
      sync2 <= sync1;
    end
  end

  // Port idles until setup-done has crossed over
  assign lcfg = sync2[15:0];
  assign lcnt = sync2[25:16];
  assign setup = lcfg[DONE_BIT];
  // Level 1 is single-PHY; Level 2 answers only its own address
  assign rx_sel = lcfg[LEVEL_BIT] |
                  addr_hit(LNK.rx_phy_select_bus,
                           lcfg[ADDR_MSB:ADDR_LSB]);
  assign tx_sel = lcfg[LEVEL_BIT] |
                  addr_hit(LNK.tx_phy_select_bus,
                           lcfg[ADDR_MSB:ADDR_LSB]);
  assign word_in = LNK.rx_word_valid & setup;
  // One permission per idle, empty-buffer spell keeps the buffer safe
  assign next_flow_go = setup & rx_sel & ~pause & (fill == 2'h0) &
                        ~word_in & ~flow_q & ~flow_go;

  // Flow pin: enable active low as ATM-end, available high as PHY-end
  always_ff @(posedge LNK.link_clk or posedge RST_I) begin
    if (RST_I) begin
      flow_go <= 1'b0;
      flow_q <= 1'b0;
      LNK.rx_enable_or_cell_avail <= 1'b1;
      LNK.rx_flow_oe <= 1'b0;
    end else begin
      flow_go <= next_flow_go;
      flow_q <= flow_go;
      // Pause shows as a held high level as ATM-end, a held low level as PHY-end
      LNK.rx_enable_or_cell_avail <= lcfg[ROLE_BIT] ? next_flow_go :
                                     ~next_flow_go;
      // Always driven as ATM-end; as PHY-end released after an unpolled cycle unless forced
      LNK.rx_flow_oe <= ~lcfg[ROLE_BIT] | lcfg[CLAV_DRV_BIT] |
                        rx_sel;
    end
  end

  // Header collection by bus width
  assign next_widx = LNK.rx_soc ? 6'h00 : widx;
  assign next_hdr = lcfg[WIDTH_BIT] ? {hdr[23:0], LNK.rx_data[7:0]} :
                    {hdr[15:0], LNK.rx_data};
  assign hdr_done = next_widx == (lcfg[WIDTH_BIT] ? HDR8 : HDR16);
  assign cell_end = next_widx == (lcfg[WIDTH_BIT] ? LAST8 : LAST16);
  // GFC bits join the compare only in NNI format
  assign unstr_hit = (((next_hdr[31:20] ^ UNSTR_VPI_I) &
                       (lcfg[FORMAT_BIT] ? 12'h0FF : 12'hFFF)) ==
                      12'h000) &&
                     (next_hdr[19:4] == UNSTR_VCI_I);

  // Word index, header and per-cell decision state
  always_ff @(posedge LNK.link_clk or posedge RST_I) begin
    if (RST_I) begin
      widx <= 6'h00;
      hdr <= 32'h0;
      is_oam <= 1'b0;
      need_lut <= 1'b0;
      CELL_UNSTR_O <= 1'b0;
      LUT_REQ_O <= 1'b0;
      LUT_ADDR_O <= 16'h0000;
    end else begin
      LUT_REQ_O <= 1'b0;
      if (word_in) begin
        widx <= next_widx + 6'h01;
        hdr <= next_hdr;
        if (hdr_done) begin
          is_oam <= next_hdr[3:2] == OAM_PTI;
          // Structured skips the compare; unstructured tries it first
          if (!lcfg[STRUCT_BIT] && unstr_hit) begin
            CELL_UNSTR_O <= 1'b1;
            need_lut <= 1'b0;
          end else begin
            CELL_UNSTR_O <= 1'b0;
            need_lut <= 1'b1;
            LUT_REQ_O <= 1'b1;
          end
          LUT_ADDR_O <= lut_addr(next_hdr[31:20], next_hdr[19:4],
                                 lcnt[M_MSB:M_LSB],
                                 lcnt[N_MSB:N_LSB]);
        end
      end
    end
  end

  // Verdict at the last word of each cell
  always_ff @(posedge LNK.link_clk or posedge RST_I) begin
    if (RST_I) begin
      CELL_DONE_O <= 1'b0;
      CELL_KEEP_O <= 1'b0;
    end else begin
      CELL_DONE_O <= word_in & cell_end;
      if (word_in && cell_end) begin
        if (is_oam) begin
          CELL_KEEP_O <= lcfg[OAM_BIT];
        end else if (need_lut) begin
          CELL_KEEP_O <= LUT_KNOWN_I | lcfg[UNROUTED_BIT];
        end else begin
          CELL_KEEP_O <= 1'b1;
        end
      end
    end
  end

  // Pause for one cycle after every cell when enabled
  always_ff @(posedge LNK.link_clk or posedge RST_I) begin
    if (RST_I) begin
      pause <= 1'b0;
    end else begin
      pause <= word_in & cell_end & lcnt[PAUSE_BIT];
    end
  end

  // Two-entry receive buffer; head entry drives the outputs
  always_ff @(posedge LNK.link_clk or posedge RST_I) begin
    if (RST_I) begin
      fill <= 2'h0;
      slot1 <= 17'h0;
      RX_VALID_O <= 1'b0;
      RX_SOC_O <= 1'b0;
      RX_DATA_O <= 16'h0000;
    end else begin
      case ({word_in, RX_VALID_O & RX_READY_I})
        2'b10: begin
          if (fill == 2'h0) begin
            {RX_SOC_O, RX_DATA_O} <= {LNK.rx_soc, LNK.rx_data};
            RX_VALID_O <= 1'b1;
          end else begin
            slot1 <= {LNK.rx_soc, LNK.rx_data};
          end
          fill <= (fill == 2'h2) ? 2'h2 : fill + 2'h1;
        end
        2'b01: begin
          {RX_SOC_O, RX_DATA_O} <= slot1;
          RX_VALID_O <= fill == 2'h2;
          fill <= fill - 2'h1;
        end
        2'b11: begin
          if (fill == 2'h1) begin
            {RX_SOC_O, RX_DATA_O} <= {LNK.rx_soc, LNK.rx_data};
          end else begin
            {RX_SOC_O, RX_DATA_O} <= slot1;
            slot1 <= {LNK.rx_soc, LNK.rx_data};
          end
        end
        default: begin
          fill <= fill;
        end
      endcase
    end
  end

  // Transmit: hold one word, send when enabled and polled
  assign send = hold_v & ~LNK.tx_enable_n & tx_sel & setup;

  always_ff @(posedge LNK.link_clk or posedge RST_I) begin
    if (RST_I) begin
      hold_v <= 1'b0;
      hold_soc <= 1'b0;
      hold_d <= 16'h0000;
      TX_READY_O <= 1'b0;
    end else begin
      if (TX_VALID_I && TX_READY_O) begin
        hold_v <= 1'b1;
        hold_soc <= TX_SOC_I;
        hold_d <= TX_DATA_I;
        TX_READY_O <= 1'b0;
      end else if (send) begin
        hold_v <= 1'b0;
        TX_READY_O <= 1'b1;
      end else begin
        TX_READY_O <= ~hold_v;
      end
    end
  end

  // Transmit pins; released between words unless forced
  always_ff @(posedge LNK.link_clk or posedge RST_I) begin
    if (RST_I) begin
      LNK.tx_word_valid <= 1'b0;
      LNK.tx_start_of_cell <= 1'b0;
      LNK.tx_cell_bus_data <= 16'h0000;
      LNK.tx_oe <= 1'b0;
    end else begin
      LNK.tx_word_valid <= send;
      LNK.tx_oe <= send | lcfg[TX_DRV_BIT];
      if (send) begin
        LNK.tx_start_of_cell <= hold_soc;
        LNK.tx_cell_bus_data <= hold_d;
      end else begin
        LNK.tx_start_of_cell <= 1'b0;
      end
    end
  end
endmodule : upc_device

// ### core/upc_far_end.sv
/*
 * Far party on the cell bus: sends cells into the device and takes
 * cells from it. Assumes it runs on the link clock with the device.
 */
`timescale 1ns/10ps
module upc_far_end (
  // Link
  upc_link_if.far LNK,
  // Control
  input wire logic RST_I,
  input wire logic PEER_IS_PHY_I,
  input wire logic [4:0] FAR_ADDR_I,
  // Words to send
  input wire logic SEND_VALID_I,
  input wire logic SEND_SOC_I,
  input wire logic [15:0] SEND_DATA_I,
  output logic SEND_READY_O,
  // Words taken
  input wire logic TAKE_ENABLE_I,
  output logic GOT_VALID_O,
  output logic GOT_SOC_O,
  output logic [15:0] GOT_DATA_O
);
  import upc_pkg::*;

  logic go; // Device permits a word this cycle

  // Flow polarity depends on the device role
  assign go = PEER_IS_PHY_I ? LNK.flow_level : ~LNK.flow_level;

  // Send one word per permitted cycle, ready ahead of the send
  always_ff @(posedge LNK.link_clk or posedge RST_I) begin
    if (RST_I) begin
      SEND_READY_O <= 1'b0;
      LNK.rx_word_valid <= 1'b0;
      LNK.rx_soc <= 1'b0;
      LNK.rx_data <= 16'h0000;
    end else begin
      SEND_READY_O <= go & ~(SEND_READY_O & SEND_VALID_I);
      LNK.rx_word_valid <= SEND_READY_O & SEND_VALID_I;
      if (SEND_READY_O & SEND_VALID_I) begin
        LNK.rx_soc <= SEND_SOC_I;
        LNK.rx_data <= SEND_DATA_I;
      end
    end
  end

  // Polling addresses and transmit enable
  always_ff @(posedge LNK.link_clk or posedge RST_I) begin
    if (RST_I) begin
      LNK.rx_phy_select_bus <= 5'h1F;
      LNK.tx_phy_select_bus <= 5'h1F;
      LNK.tx_enable_n <= 1'b1;
    end else begin
      LNK.rx_phy_select_bus <= FAR_ADDR_I;
      LNK.tx_phy_select_bus <= FAR_ADDR_I;
      LNK.tx_enable_n <= ~TAKE_ENABLE_I;
    end
  end

  // Capture words the device sends
  always_ff @(posedge LNK.link_clk or posedge RST_I) begin
    if (RST_I) begin
      GOT_VALID_O <= 1'b0;
      GOT_SOC_O <= 1'b0;
      GOT_DATA_O <= 16'h0000;
    end else begin
      GOT_VALID_O <= LNK.tx_valid_level;
      GOT_SOC_O <= LNK.tx_start_of_cell;
      GOT_DATA_O <= LNK.tx_cell_bus_data;
    end
  end
endmodule : upc_far_end

// ### core/upc_link_if.sv
/*
 * Cell-bus link between the configured port and the far party.
 * Assumes the bench drives link_clk; released flow and transmit valid pins read as zero here.
 */
`timescale 1ns/10ps
interface upc_link_if;
  logic link_clk;             // Link clock from the bench
  logic rx_port_clk;          // Device-driven receive clock
  logic rx_port_clk_oe;       // Receive clock driven by device
  logic tx_port_clk;          // Device-driven transmit clock
  logic tx_port_clk_oe;       // Transmit clock driven by device
  logic rx_soc;               // Far end: start of cell
  logic [15:0] rx_data;       // Far end: receive word
  logic rx_word_valid;        // Far end: word present
  logic [4:0] rx_phy_select_bus;  // Far end: receive poll address
  logic rx_enable_or_cell_avail;  // Device: receive flow control
  logic rx_flow_oe;           // Device: flow pin driven
  logic tx_start_of_cell;     // Device: start of cell
  logic [15:0] tx_cell_bus_data;  // Device: transmit word
  logic tx_word_valid;        // Device: word present
  logic tx_oe;                // Device: transmit pins driven
  logic tx_enable_n;          // Far end: takes transmit words
  logic [4:0] tx_phy_select_bus;  // Far end: transmit poll address
  logic flow_level;           // Resolved flow pin
  logic tx_valid_level;       // Resolved transmit valid

  // Released pins settle low
  assign flow_level = rx_flow_oe & rx_enable_or_cell_avail;
  assign tx_valid_level = tx_oe & tx_word_valid;

  modport device (
    input link_clk, rx_soc, rx_data, rx_word_valid, rx_phy_select_bus,
    input tx_enable_n, tx_phy_select_bus,
    output rx_port_clk, rx_port_clk_oe, tx_port_clk, tx_port_clk_oe,
    output rx_enable_or_cell_avail, rx_flow_oe,
    output tx_start_of_cell, tx_cell_bus_data, tx_word_valid, tx_oe
  );
  modport far (
    input link_clk, flow_level, tx_valid_level,
    input tx_start_of_cell, tx_cell_bus_data,
    output rx_soc, rx_data, rx_word_valid, rx_phy_select_bus,
    output tx_enable_n, tx_phy_select_bus
  );
endinterface : upc_link_if

// ### core/upc_pkg.sv
/*
 * Constants, field layout and helper functions shared by both ends of
 * the cell-port configuration block and its link.
 * Assumes a 16-bit register port with byte addresses and a 16-bit link.
 */
// Summary of operation
// - Bit 0 one selects structured routing
// - Unstructured compares header first, then look-up
// - Bit 1 UNI; NNI adds GFC to compare
// - Bit 2 external clock; zero drives half-rate
// - Bit 3 keeps OAM cells, else discards
// - Width bit: one 8-bit, zero 16-bit
// - Bit 5 one Level 1, zero Level 2
// - Bit 6 keeps unrouted cells, else discards
// - Bit 7 keeps cell-available always driven
// - Override keeps start-of-cell and data driven
// - Role bit: one PHY-end, zero ATM-end
// - Bits 14:10 address, only 00h to 1Eh
// - Setup-done set after clock select, kept set
// - Software clears look-up entries to 0003h first
// - Bits 3:0 VPI count, 0 to 12
// - Bits 8:4 VCI count, 4 to 16
// - Look-up bits total 4 to 16
// - Bit 9 pauses receive after each cell
package upc_pkg;
  // Register byte addresses and values after reset
  localparam logic [15:0] CFG_OFFSET = 16'h4000;
  localparam logic [15:0] CNT_OFFSET = 16'h4002;
  localparam logic [15:0] CFG_RESET = 16'h0004;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MASK = 16'h03FF;
  // Port configuration field positions
  localparam int STRUCT_BIT = 0;
  localparam int FORMAT_BIT = 1;
  localparam int CLKSRC_BIT = 2;
  localparam int OAM_BIT = 3;
  localparam int WIDTH_BIT = 4;
  localparam int LEVEL_BIT = 5;
  localparam int UNROUTED_BIT = 6;
  localparam int CLAV_DRV_BIT = 7;
  localparam int TX_DRV_BIT = 8;
  localparam int ROLE_BIT = 9;
  localparam int ADDR_LSB = 10;
  localparam int ADDR_MSB = 14;
  localparam int DONE_BIT = 15;
  // Header bit count field positions
  localparam int M_LSB = 0;
  localparam int M_MSB = 3;
  localparam int N_LSB = 4;
  localparam int N_MSB = 8;
  localparam int PAUSE_BIT = 9;
  // Legal ranges
  localparam logic [4:0] ADDR_MAX = 5'h1E;
  localparam logic [4:0] M_MAX = 5'h0C;
  localparam logic [4:0] N_MIN = 5'h04;
  localparam logic [4:0] N_MAX = 5'h10;
  localparam logic [15:0] LUT_CLEAR = 16'h0003;
  // Cell framing: last word index per width, last header word index
  localparam logic [5:0] LAST16 = 6'h1A;
  localparam logic [5:0] LAST8 = 6'h34;
  localparam logic [5:0] HDR16 = 6'h01;
  localparam logic [5:0] HDR8 = 6'h03;
  localparam logic [1:0] OAM_PTI = 2'h2;

  // Multi-PHY address match; 1Fh is never a valid device address
  function automatic logic addr_hit(input logic [4:0] bus,
                                    input logic [4:0] dev);
    addr_hit = (bus == dev) && (dev <= ADDR_MAX);
  endfunction : addr_hit

  // Look-up address from M VPI bits above N VCI bits, clamped to range
  function automatic logic [15:0] lut_addr(input logic [11:0] vpi,
                                           input logic [15:0] vci,
                                           input logic [3:0] m_raw,
                                           input logic [4:0] n_raw);
    logic [4:0] m;
    logic [4:0] n;
    logic [31:0] vm;
    logic [31:0] cm;
    m = ({1'b0, m_raw} > M_MAX) ? M_MAX : {1'b0, m_raw};
    n = (n_raw < N_MIN) ? N_MIN : ((n_raw > N_MAX) ? N_MAX : n_raw);
    if (m > N_MAX - n) begin
      m = N_MAX - n;
    end
    vm = (32'h1 << m) - 32'h1;
    cm = (32'h1 << n) - 32'h1;
    lut_addr = 16'(((({20'h0, vpi}) & vm) << n) | ({16'h0, vci} & cm));
  endfunction : lut_addr
endpackage : upc_pkg

// ### test/tb_top.sv
/* Bench top: both link ends, their link and checker; register,
   receive-cell and transmit tests.
   Assumes package, link interface and checker are compiled first. */
`timescale 1ns/10ps
module tb_top;
  import upc_pkg::*;
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, lut_addr, rx_data, got_data;
  logic lut_known = 1'b0; // Entries start cleared, so unknown
  logic lut_req, cell_done, cell_keep, rx_valid, rx_soc, tx_ready;
  logic cell_unstr;
  logic rx_ready = 1'b0;
  logic tx_valid = 1'b0;
  logic tx_soc = 1'b0;
  logic [15:0] tx_data = 16'h0000;
  logic send_valid = 1'b0;
  logic send_soc = 1'b0;
  logic [15:0] send_data = 16'h0000;
  logic send_ready, got_valid, got_soc;
  logic take_en = 1'b0;
  logic [16:0] exp_rx[$];
  logic [16:0] exp_tx[$];
  int lut_reqs = 0;
  int num_errors = 0;
  int comparisons = 0;
  upc_link_if lnk ();
  // Match values equal the test header except its GFC nibble
  upc_device u_upc_device (.CLK_I(clk), .RST_I(rst),
    .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr),
    .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .LNK(lnk),
    .UNSTR_VPI_I(12'hF12), .UNSTR_VCI_I(16'h3456),
    .LUT_KNOWN_I(lut_known), .LUT_REQ_O(lut_req), .LUT_ADDR_O(lut_addr),
    .CELL_DONE_O(cell_done), .CELL_KEEP_O(cell_keep),
    .CELL_UNSTR_O(cell_unstr),
    .RX_VALID_O(rx_valid), .RX_SOC_O(rx_soc), .RX_DATA_O(rx_data),
    .RX_READY_I(rx_ready), .TX_VALID_I(tx_valid), .TX_SOC_I(tx_soc),
    .TX_DATA_I(tx_data), .TX_READY_O(tx_ready));
  upc_far_end u_upc_far_end (.LNK(lnk), .RST_I(rst),
    .PEER_IS_PHY_I(1'b1), .FAR_ADDR_I(5'h05), .SEND_VALID_I(send_valid),
    .SEND_SOC_I(send_soc), .SEND_DATA_I(send_data),
    .SEND_READY_O(send_ready), .TAKE_ENABLE_I(take_en),
    .GOT_VALID_O(got_valid), .GOT_SOC_O(got_soc), .GOT_DATA_O(got_data));
  upc_link_properties u_upc_link_properties (.CLK_I(clk), .RST_I(rst),
    .link_clk(lnk.link_clk), .rx_port_clk(lnk.rx_port_clk),
    .rx_port_clk_oe(lnk.rx_port_clk_oe), .tx_port_clk(lnk.tx_port_clk),
    .tx_port_clk_oe(lnk.tx_port_clk_oe), .rx_soc(lnk.rx_soc),
    .rx_word_valid(lnk.rx_word_valid),
    .tx_start_of_cell(lnk.tx_start_of_cell),
    .tx_word_valid(lnk.tx_word_valid), .tx_oe(lnk.tx_oe));
  // System clock 50 ns, link clock 30 ns at an odd phase
  initial begin
    forever #25 clk = ~clk;
  end
  initial begin
    lnk.link_clk = 1'b0;
    #7;
    forever #15 lnk.link_clk = ~lnk.link_clk;
  end
  // Receiver stalls every other cycle; monitors check words in order
  always @(posedge lnk.link_clk) begin
    rx_ready <= ~rx_ready;
    if (lut_req === 1'b1) begin
      lut_reqs++;
    end
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      check({rx_soc, rx_data}, exp_rx.pop_front());
    end
    if (got_valid === 1'b1) begin
      check({got_soc, got_data}, exp_tx.pop_front());
    end
  end
  // Compare and count
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Bounded wait on the link clock for a flag
  task automatic wait_link(ref logic s);
    int n;
    n = 0;
    do begin
      @(posedge lnk.link_clk);
      n++;
    end while (s !== 1'b1 && n < 600);
    if (s !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED %0t wait timed out", $time);
      conclude();
    end
  endtask : wait_link
  // Register write and read, one-cycle strobes
  task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    check({1'b0, reg_rdata}, {1'b0, e});
  endtask : reg_read
  // One 27-word cell from the far end, then its verdict
  task automatic send_cell(input logic known, input logic keep,
                           input logic unstr);
    logic [15:0] w;
    @(posedge lnk.link_clk);
    lut_known <= known;
    for (int i = 0; i < 27; i++) begin
      w = (i == 0) ? 16'h0123 : (i == 1) ? 16'h4560 : {8'hC0, 8'(i)};
      send_valid <= 1'b1;
      send_soc <= (i == 0);
      send_data <= w;
      exp_rx.push_back({(i == 0), w});
      wait_link(send_ready);
    end
    send_valid <= 1'b0;
    wait_link(cell_done);
    check({16'h0000, cell_keep}, {16'h0000, keep});
    check({16'h0000, cell_unstr}, {16'h0000, unstr});
    check({1'b0, lut_addr}, 17'h00256);
  endtask : send_cell
  // One word to the far end, spaced two cycles
  task automatic tx_word(input logic s, input logic [15:0] d);
    repeat (2) @(posedge lnk.link_clk);
    tx_valid <= 1'b1;
    tx_soc <= s;
    tx_data <= d;
    exp_tx.push_back({s, d});
    wait_link(tx_ready);
    tx_valid <= 1'b0;
  endtask : tx_word
  // Verdict
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    reg_read(CFG_OFFSET, CFG_RESET);
    reg_read(CNT_OFFSET, CNT_RESET);
    reg_read(16'h4004, 16'h0000);
    check({16'h0000, lnk.rx_port_clk_oe}, 17'h00000);
    $display("test reset values done");
    reg_write(CNT_OFFSET, 16'hFFFF);
    reg_read(CNT_OFFSET, CNT_MASK);
    reg_write(CNT_OFFSET, 16'h0084);
    reg_read(CNT_OFFSET, 16'h0084);
    reg_write(CFG_OFFSET, 16'h16A3);
    reg_read(CFG_OFFSET, 16'h16A3);
    reg_write(CFG_OFFSET, 16'h96A3);
    reg_read(CFG_OFFSET, 16'h96A3);
    check({16'h0000, lnk.rx_port_clk_oe}, 17'h00001);
    $display("test register access done");
    repeat (10) @(posedge lnk.link_clk);
    take_en <= 1'b1;
    send_cell(1'b1, 1'b1, 1'b0);
    send_cell(1'b0, 1'b0, 1'b0);
    // Unstructured routing: header match in UNI format, no look-up
    reg_write(CFG_OFFSET, 16'h96A2);
    send_cell(1'b0, 1'b1, 1'b1);
    $display("test receive cells done");
    tx_word(1'b1, 16'hA5A5);
    tx_word(1'b0, 16'h5A5A);
    tx_word(1'b0, 16'h0F0F);
    for (int n = 0; n < 300 && exp_rx.size() + exp_tx.size() > 0; n++) begin
      @(posedge lnk.link_clk);
    end
    check(17'(exp_rx.size() + exp_tx.size()), 17'h00000);
    check(17'(lut_reqs), 17'h00002);
    $display("test transmit words done");
    conclude();
  end
endmodule : tb_top

// ### test/upc_link_properties.sv
/* Checker beside the cell-bus link: port clocks, word and start timing.
   Assumes RST_I resets both the system and the link clock domains. */
`timescale 1ns/10ps
module upc_link_properties (
  // Clocks and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic link_clk,
  // Port clocks
  input wire logic rx_port_clk,
  input wire logic rx_port_clk_oe,
  input wire logic tx_port_clk,
  input wire logic tx_port_clk_oe,
  // Words on the link
  input wire logic rx_soc,
  input wire logic rx_word_valid,
  input wire logic tx_start_of_cell,
  input wire logic tx_word_valid,
  input wire logic tx_oe
);
  // Driven port clock flips on every rising system clock edge
  clk_half_rate_a:
    assert property (@(posedge CLK_I) disable iff (RST_I)
      rx_port_clk_oe && $past(rx_port_clk_oe) |->
      rx_port_clk != $past(rx_port_clk))
    else $error("port clock not at half rate");
  // Both port clock pins are driven together and alike
  clk_pins_pair_a:
    assert property (@(posedge CLK_I) disable iff (RST_I)
      rx_port_clk_oe |-> tx_port_clk_oe && tx_port_clk == rx_port_clk)
    else $error("port clock pins differ");
  clk_pins_off_a:
    assert property (@(posedge CLK_I) disable iff (RST_I)
      !rx_port_clk_oe |-> !tx_port_clk_oe)
    else $error("transmit clock driven alone");
  // A word is never put on released pins
  tx_word_driven_a:
    assert property (@(posedge link_clk) disable iff (RST_I)
      tx_word_valid |-> tx_oe)
    else $error("transmit word on released pins");
  // Transmit words stand one cycle each
  tx_word_single_a:
    assert property (@(posedge link_clk) disable iff (RST_I)
      tx_word_valid |=> !tx_word_valid)
    else $error("transmit words too close");
  // Receive words are spaced at least three cycles
  rx_word_spacing_a:
    assert property (@(posedge link_clk) disable iff (RST_I)
      rx_word_valid |=> !rx_word_valid [*2])
    else $error("receive words too close");
  // Start of cell only rises with a word
  rx_soc_word_a:
    assert property (@(posedge link_clk) disable iff (RST_I)
      $rose(rx_soc) |-> rx_word_valid)
    else $error("receive start without word");
  tx_soc_word_a:
    assert property (@(posedge link_clk) disable iff (RST_I)
      $rose(tx_start_of_cell) |-> tx_word_valid)
    else $error("transmit start without word");
  // Main scenarios reached
  cover property (@(posedge link_clk) rx_word_valid && rx_soc);
  cover property (@(posedge link_clk) tx_word_valid && tx_start_of_cell);
  cover property (@(posedge CLK_I) rx_port_clk_oe);
endmodule : upc_link_properties
